// ==== core/ppg_pkg.sv ====
// Purpose: shared types of the pulse timer channel pair
// Assumes: constants live in ppg_timing_regs.svh
// Notes:   control fields travel together as one struct
package ppg_pkg;

  // software control word
  typedef struct packed {
    logic [2:0] modulation_cycle_select_a; // modulation cycle length code
    logic [3:0] prescale_select;           // count clock divider code
    logic       interlock;                 // interlock mode
    logic       enable;                    // counter run
  } ctrl_t;

endpackage

// ==== core/ppg_prescaler.sv ====
// Purpose: makes the prescaled count clock as a one-cycle tick
// Assumes: runs on the system clock, selector from software
// Notes:   prohibited codes fall back to undivided so the counter never stalls
`timescale 1ns/100ps
`include "ppg_timing_regs.svh"

module ppg_prescaler #(
  parameter int DIV_W = 4               // divider width, largest ratio 2**DIV_W
) (
  input  wire logic             clk_sys_i,
  input  wire logic             rstn_i,
  input  wire logic [3:0]       prescale_select_i,
  output logic                  tick_o
);

  logic [DIV_W-1:0] div_q;              // free running divider
  logic [DIV_W-1:0] div_d;
  logic [DIV_W-1:0] mask;               // ratio minus one

  // decode the selector into a terminal mask
  always_comb begin
    div_d = div_q + {{(DIV_W-1){1'b0}}, 1'b1};
    unique case (prescale_select_i)
      `PSC_DIV2:  mask = DIV_W'(4'h1);
      `PSC_DIV4:  mask = DIV_W'(4'h3);
      `PSC_DIV8:  mask = DIV_W'(4'h7);
      `PSC_DIV16: mask = DIV_W'(4'hf);
      default:    mask = '0;           // undivided and prohibited codes
    endcase
    tick_o = (div_q & mask) == mask;
  end

  // divider register
  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      div_q <= '0;
    end else begin
      div_q <= div_d;
    end
  end

endmodule

// ==== core/ppg_timing_core.sv ====
// Purpose: timing registers and pulse generation of a 16-bit pulse timer channel pair
// Assumes: plain register port, read data one cycle after the read strobe
// Notes:   all counting advances on the prescaled tick only
//
// Overview of operation
// - interlock mode applies modulation rate to channel zero
// - valid rate bits follow modulation cycle select
// - rate counts waves with trailing edge delayed
// - register three places channel one leading edge
// - prescale select divides timer clock or undivided
// - register one places channel zero leading edge
// - register zero sets the output cycle
//
// The register offsets and the plain strobed port were chosen for this implementation.
`timescale 1ns/100ps
`include "ppg_timing_regs.svh"

module ppg_timing_core #(
  parameter int CNT_W = 16              // counter and compare width
) (
  input  wire logic             clk_sys_i,
  input  wire logic             rstn_i,
  input  wire logic [3:0]       addr_i,
  input  wire logic [31:0]      wdata_i,
  input  wire logic             we_i,
  input  wire logic             re_i,
  output logic [31:0]           rdata_o,
  output logic                  ch0_pulse_output_o,
  output logic                  ch1_pulse_output_o
);

  // software registers
  logic [CNT_W-1:0]    cycle_value_q, cycle_value_d;
  logic [CNT_W-1:0]    ch0_lead_q, ch0_lead_d;
  logic [CNT_W-1:0]    ch0_timing_q, ch0_timing_d;
  logic [3:0]          rate_q, rate_d;
  logic [CNT_W-1:0]    ch1_lead_q, ch1_lead_d;
  ppg_pkg::ctrl_t      ctrl_q, ctrl_d;
  logic [31:0]         rdata_q, rdata_d;
  // timing state
  logic [CNT_W-1:0]    cnt_q, cnt_d;     // wave counter
  logic [3:0]          wave_q, wave_d;   // wave index in modulation cycle
  logic                p0_q, p0_d;
  logic                p1_q, p1_d;
  logic                tick;             // prescaled count clock
  logic                wrap;             // end of one rectangular wave
  logic [3:0]          eff_rate;         // rate after masking invalid bits
  logic [3:0]          wave_mask;        // modulation cycle length minus one
  logic                delay;            // this wave has its trailing edge late
  logic [CNT_W:0]      trail0;           // channel zero trailing match

  ppg_prescaler #(
    .DIV_W (4)
  ) u_psc (
    .clk_sys_i         (clk_sys_i),
    .rstn_i            (rstn_i),
    .prescale_select_i (ctrl_q.prescale_select),
    .tick_o            (tick)
  );

  // register write and read decode
  always_comb begin
    cycle_value_d = cycle_value_q;
    ch0_lead_d    = ch0_lead_q;
    ch0_timing_d  = ch0_timing_q;
    rate_d        = rate_q;
    ch1_lead_d    = ch1_lead_q;
    ctrl_d        = ctrl_q;
    rdata_d       = 32'h0000_0000;
    if (we_i) begin
      unique case (addr_i)
        `ADDR_CYCLE:      cycle_value_d = wdata_i[CNT_W-1:0];
        `ADDR_CH0_LEAD:   ch0_lead_d    = wdata_i[CNT_W-1:0];
        `ADDR_CH0_TIMING: begin
          ch0_timing_d = wdata_i[`TIM_MSB:`TIM_LSB];
          rate_d       = wdata_i[`RATE_MSB:`RATE_LSB];
        end
        `ADDR_CH1_LEAD:   ch1_lead_d    = wdata_i[CNT_W-1:0];
        `ADDR_CTRL: begin
          // fields placed one by one: the packed word has no hole where register bits 3:2 stay unused
          ctrl_d.enable                    = wdata_i[`CTRL_EN_BIT];
          ctrl_d.interlock                 = wdata_i[`CTRL_IL_BIT];
          ctrl_d.prescale_select           = wdata_i[`CTRL_PSC_MSB:`CTRL_PSC_LSB];
          ctrl_d.modulation_cycle_select_a = wdata_i[`CTRL_MSEL_MSB:`CTRL_MSEL_LSB];
        end
        default:          ;                                       // status and holes ignore writes
      endcase
    end
    if (re_i) begin
      unique case (addr_i)
        `ADDR_CYCLE:      rdata_d = {16'h0000, cycle_value_q};
        `ADDR_CH0_LEAD:   rdata_d = {16'h0000, ch0_lead_q};
        `ADDR_CH0_TIMING: rdata_d = {12'h000, ch0_timing_q, rate_q};
        `ADDR_CH1_LEAD:   rdata_d = {16'h0000, ch1_lead_q};
        `ADDR_CTRL:       rdata_d = {21'h000000, ctrl_q.modulation_cycle_select_a, ctrl_q.prescale_select,
                                     2'b00, ctrl_q.interlock, ctrl_q.enable};
        `ADDR_STATUS:     rdata_d = {14'h0000, p1_q, p0_q, cnt_q};
        default:          rdata_d = 32'h0000_0000;                   // unmapped reads zero
      endcase
    end
  end

  // modulation rate: only the top bits that the cycle select allows count
  always_comb begin
    unique case (ctrl_q.modulation_cycle_select_a)
      `MSEL_1B: begin eff_rate = {3'h0, rate_q[3]};   wave_mask = 4'h1; end
      `MSEL_2B: begin eff_rate = {2'h0, rate_q[3:2]}; wave_mask = 4'h3; end
      `MSEL_3B: begin eff_rate = {1'h0, rate_q[3:1]}; wave_mask = 4'h7; end
      `MSEL_4B: begin eff_rate = rate_q;              wave_mask = 4'hf; end
      default:  begin eff_rate = `RST_RATE;           wave_mask = 4'h0; end // none or illegal
    endcase
    // first eff_rate waves of each modulation cycle are stretched
    delay  = ctrl_q.interlock && (wave_q < eff_rate);
    trail0 = {1'b0, ch0_timing_q} + {{CNT_W{1'b0}}, delay};
  end

  // counter and pulse next state
  always_comb begin
    // the cycle comes from register zero even in interlock mode
    wrap  = cnt_q >= cycle_value_q;
    cnt_d = cnt_q;
    wave_d = wave_q;
    p0_d  = p0_q;
    p1_d  = p1_q;
    if (!ctrl_q.enable) begin
      cnt_d  = `RST_WORD16;
      wave_d = 4'h0;
      p0_d   = 1'b0;
      p1_d   = 1'b0;
    end else if (tick) begin
      cnt_d = wrap ? `RST_WORD16 : cnt_q + 16'h0001;
      if (wrap) begin
        wave_d = (wave_q + 4'h1) & wave_mask;
      end
      // trailing edges first so a leading match on the same count wins
      if ({1'b0, cnt_q} == trail0) begin
        p0_d = 1'b0;
      end
      if (wrap) begin
        p1_d = 1'b0;
      end
      if (cnt_q == ch0_lead_q) begin
        p0_d = 1'b1;
      end
      if (cnt_q == ch1_lead_q) begin
        p1_d = 1'b1;
      end
    end
  end

  // every register of the block
  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      cycle_value_q <= `RST_WORD16;
      ch0_lead_q    <= `RST_WORD16;
      ch0_timing_q  <= `RST_WORD16;
      rate_q        <= `RST_RATE;
      ch1_lead_q    <= `RST_WORD16;
      ctrl_q        <= '0;
      rdata_q       <= 32'h0000_0000;
      cnt_q         <= `RST_WORD16;
      wave_q        <= 4'h0;
      p0_q          <= 1'b0;
      p1_q          <= 1'b0;
    end else begin
      cycle_value_q <= cycle_value_d;
      ch0_lead_q    <= ch0_lead_d;
      ch0_timing_q  <= ch0_timing_d;
      rate_q        <= rate_d;
      ch1_lead_q    <= ch1_lead_d;
      ctrl_q        <= ctrl_d;
      rdata_q       <= rdata_d;
      cnt_q         <= cnt_d;
      wave_q        <= wave_d;
      p0_q          <= p0_d;
      p1_q          <= p1_d;
    end
  end

  assign rdata_o            = rdata_q;
  assign ch0_pulse_output_o = p0_q;
  assign ch1_pulse_output_o = p1_q;

  // checks
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!rstn_i);

  AST_CH1_UPPER_ZERO: assert property (
    re_i && addr_i == `ADDR_CH1_LEAD |=> rdata_o[31:16] == 16'h0000)
    else $error("upper bits of register three not zero");
  AST_UNDIV_TICK: assert property (
    ctrl_q.prescale_select == `PSC_UNDIV |-> tick)
    else $error("undivided count clock missed a tick");
  AST_DIV2_GAP: assert property (
    tick && ctrl_q.prescale_select == `PSC_DIV2 ##1 ctrl_q.prescale_select == `PSC_DIV2 |-> !tick)
    else $error("divide by two ticked twice in a row");
  AST_CH1_LEAD: assert property (
    ctrl_q.enable && tick && cnt_q == ch1_lead_q |=> ch1_pulse_output_o)
    else $error("channel one did not rise at its lead value");
  AST_CH0_LEAD: assert property (
    ctrl_q.enable && tick && cnt_q == ch0_lead_q |=> ch0_pulse_output_o)
    else $error("channel zero did not rise at its lead value");
  AST_WRAP: assert property (
    ctrl_q.enable && tick && cnt_q >= cycle_value_q |=> cnt_q == `RST_WORD16)
    else $error("counter did not restart at the cycle value");
  AST_DELAYED_TRAIL: assert property (
    ctrl_q.enable && tick && delay && p0_q && cnt_q == ch0_timing_q && cnt_q != ch0_lead_q
    |=> ch0_pulse_output_o)
    else $error("delayed wave ended on time");
  AST_PLAIN_TRAIL: assert property (
    ctrl_q.enable && tick && !delay && cnt_q == ch0_timing_q && cnt_q != ch0_lead_q
    |=> !ch0_pulse_output_o)
    else $error("undelayed wave did not end at its timing value");
  AST_RATE_NONE: assert property (
    ctrl_q.modulation_cycle_select_a == `MSEL_NONE |-> eff_rate == 4'h0 && !delay)
    else $error("rate applied with no modulation cycle");
  AST_RATE_ONE: assert property (
    ctrl_q.modulation_cycle_select_a == `MSEL_1B |-> eff_rate == {3'h0, rate_q[3]})
    else $error("wrong valid bits for one-bit cycle");

  COV_WRAP:  cover property (ctrl_q.enable && tick && wrap);
  COV_DELAY: cover property (ctrl_q.enable && tick && delay && cnt_q == ch0_timing_q);
  COV_RISE1: cover property (!ch1_pulse_output_o ##1 ch1_pulse_output_o);
  // longest modulation cycle completes in interlock mode
  COV_MOD16: cover property (ctrl_q.interlock && ctrl_q.modulation_cycle_select_a == `MSEL_4B && tick && wrap
                             && wave_q == 4'hf);

endmodule

// ==== core/ppg_timing_regs.svh ====
// Purpose: register offsets, field positions and reset values of the pulse timer channel pair
// Assumes: word-indexed plain register port, 4-bit address
// Notes:   definitions only
`ifndef PPG_TIMING_REGS_SVH
`define PPG_TIMING_REGS_SVH

// register indices on the plain port
`define ADDR_CYCLE       4'h0
`define ADDR_CH0_LEAD    4'h1
`define ADDR_CH0_TIMING  4'h2
`define ADDR_CH1_LEAD    4'h3
`define ADDR_CTRL        4'h4
`define ADDR_STATUS      4'h5

// timing register two layout
`define TIM_MSB          19
`define TIM_LSB          4
`define RATE_MSB         3
`define RATE_LSB         0
`define REG2_MSB         19

// control register layout
`define CTRL_EN_BIT      0
`define CTRL_IL_BIT      1
`define CTRL_PSC_MSB     7
`define CTRL_PSC_LSB     4
`define CTRL_MSEL_MSB    10
`define CTRL_MSEL_LSB    8

// reset values
`define RST_WORD16       16'h0000
`define RST_RATE         4'h0

// prescale codes
`define PSC_UNDIV        4'h0
`define PSC_DIV2         4'h8
`define PSC_DIV4         4'h9
`define PSC_DIV8         4'ha
`define PSC_DIV16        4'hb

// modulation cycle select codes
`define MSEL_NONE        3'h0
`define MSEL_1B          3'h1
`define MSEL_2B          3'h2
`define MSEL_3B          3'h3
`define MSEL_4B          3'h4

`endif

// ==== dv/ppg_timing_and_rate_regs_tb_top.sv ====
// Purpose: self-checking bench for the pulse timer timing and modulation-rate registers
// Assumes: plain register port, read data one cycle after the strobe, prescaled tick inside the design
// Notes:   pulse checks count output levels over whole modulation cycles, so start phase does not matter
`timescale 1ns/100ps
`include "ppg_timing_regs.svh"

module ppg_timing_and_rate_regs_tb_top;
  typedef struct packed {
    logic [3:0]  a;  // register index
    logic [31:0] d;  // word written
    logic [31:0] e;  // word expected back
  } rrow_t;
  typedef struct packed {
    ppg_pkg::ctrl_t c;     // control word for this case
    logic [3:0]     rate;  // modulation rate field
    logic [7:0]     hi;    // channel zero high cycles per 64
    logic [7:0]     rise;  // rising edges per 64 cycles
  } prow_t;

  logic        clk_sys_i;  // system clock
  logic        rstn_i;     // async reset, active low
  logic [3:0]  addr_i;     // register index
  logic [31:0] wdata_i;    // write data
  logic        we_i;       // write strobe
  logic        re_i;       // read strobe
  logic [31:0] rdata_o;    // read data
  logic        ch0_o;      // channel zero pulse
  logic        ch1_o;      // channel one pulse
  int          failures;   // mismatches seen
  int          tests_run;  // comparisons made
  int          cycles;     // run length guard
  logic [31:0] got;        // last read word
  int          hi0, r0, r1;
  rrow_t       rr[7];
  prow_t       pr[13];

  ppg_timing_core u_ppg_timing_core (.clk_sys_i(clk_sys_i), .rstn_i(rstn_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .we_i(we_i), .re_i(re_i), .rdata_o(rdata_o),
    .ch0_pulse_output_o(ch0_o), .ch1_pulse_output_o(ch1_o));

  // 125 mhz clock
  initial begin
    clk_sys_i = 1'b0;
    forever #4 clk_sys_i = ~clk_sys_i;
  end

  // hang guard, well above the expected run of about 2000 cycles
  always @(posedge clk_sys_i) begin
    cycles++;
    if (cycles == 20000) begin
      failures++;
      tally_and_finish();
    end
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
    tests_run++;
    if (seen !== exp) begin
      failures++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // one write cycle, then an idle edge so the strobe is never reassigned in one step
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    addr_i <= a;
    wdata_i <= d;
    we_i <= 1'b1;
    @(posedge clk_sys_i);
    we_i <= 1'b0;
    @(posedge clk_sys_i);
  endtask

  // read strobe, data taken in the following cycle only
  task automatic rd(input logic [3:0] a, output logic [31:0] d);
    addr_i <= a;
    re_i <= 1'b1;
    @(posedge clk_sys_i);
    re_i <= 1'b0;
    #1 d = rdata_o;
    @(posedge clk_sys_i);
    #1 chk(rdata_o, 32'h0000_0000, "rdata after one cycle");
    @(posedge clk_sys_i);
  endtask

  // counts channel zero high cycles and rising edges of both outputs
  task automatic measure(input int n);
    logic p0, p1;
    hi0 = 0; r0 = 0; r1 = 0;
    // start sample taken once the edge has settled, so no rise slips between it and the first sample
    #1 p0 = ch0_o;
    p1 = ch1_o;
    repeat (n) begin
      @(posedge clk_sys_i);
      #1 hi0 += int'(ch0_o);
      r0 += int'(ch0_o & ~p0);
      r1 += int'(ch1_o & ~p1);
      p0 = ch0_o; p1 = ch1_o;
    end
  endtask

  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  initial begin
    rstn_i = 1'b0; addr_i = 4'h0; wdata_i = 32'h0000_0000; we_i = 1'b0; re_i = 1'b0;
    failures = 0; tests_run = 0; cycles = 0;
    // upper bits dropped, holes read zero
    rr = '{'{`ADDR_CH0_TIMING, 32'hffff_ffff, 32'h000f_ffff}, '{`ADDR_CH0_TIMING, 32'h8abc_def5, 32'h000c_def5},
           '{`ADDR_CH1_LEAD, 32'hffff_ffff, 32'h0000_ffff}, '{`ADDR_CH0_LEAD, 32'hffff_1234, 32'h0000_1234},
           '{`ADDR_CYCLE, 32'ha5a5_5a5a, 32'h0000_5a5a}, '{`ADDR_CTRL, 32'hffff_ffff, 32'h0000_07f3},
           '{4'h6, 32'hffff_ffff, 32'h0000_0000}};
    // cycle 3, lead 1, trail 2: one high count per wave unless delayed
    pr = '{'{{3'h0, `PSC_UNDIV, 2'b01}, 4'h0, 8'h10, 8'h10}, '{{3'h0, `PSC_DIV2, 2'b01}, 4'h0, 8'h10, 8'h08},
           '{{3'h0, `PSC_DIV4, 2'b01}, 4'h0, 8'h10, 8'h04}, '{{3'h0, `PSC_DIV8, 2'b01}, 4'h0, 8'h10, 8'h02},
           '{{3'h0, `PSC_DIV16, 2'b01}, 4'h0, 8'h10, 8'h01}, '{{3'h0, 4'h1, 2'b01}, 4'h0, 8'h10, 8'h10},
           '{{`MSEL_1B, 4'h0, 2'b11}, 4'h8, 8'h18, 8'h10}, '{{`MSEL_NONE, 4'h0, 2'b11}, 4'hf, 8'h10, 8'h10},
           '{{`MSEL_4B, 4'h0, 2'b11}, 4'h3, 8'h13, 8'h10}, '{{`MSEL_4B, 4'h0, 2'b01}, 4'h3, 8'h10, 8'h10},
           '{{`MSEL_2B, 4'h0, 2'b11}, 4'h4, 8'h14, 8'h10}, '{{`MSEL_3B, 4'h0, 2'b11}, 4'h6, 8'h16, 8'h10},
           '{{3'h7, 4'h0, 2'b11}, 4'hf, 8'h10, 8'h10}};
    repeat (5) @(posedge clk_sys_i);
    rstn_i <= 1'b1;
    @(posedge clk_sys_i);
    // register rows
    foreach (rr[i]) begin
      wr(rr[i].a, rr[i].d);
      rd(rr[i].a, got);
      chk(got, rr[i].e, "register readback");
    end
    $display("register rows done");
    // pulse rows
    wr(`ADDR_CYCLE, 32'h0000_0003);
    wr(`ADDR_CH0_LEAD, 32'h0000_0001);
    wr(`ADDR_CH1_LEAD, 32'h0000_0002);
    foreach (pr[i]) begin
      wr(`ADDR_CH0_TIMING, {12'h000, 16'h0002, pr[i].rate});
      // control word laid out as the register has it, bits 3:2 left zero
      wr(`ADDR_CTRL, {21'h000000, pr[i].c.modulation_cycle_select_a, pr[i].c.prescale_select,
                      2'b00, pr[i].c.interlock, pr[i].c.enable});
      repeat (80) @(posedge clk_sys_i);
      measure(64);
      chk(32'(hi0), {24'h000000, pr[i].hi}, "ch0 high cycles");
      chk(32'(r0), {24'h000000, pr[i].rise}, "ch0 rises");
      chk(32'(r1), {24'h000000, pr[i].rise}, "ch1 rises");
    end
    $display("pulse rows done");
    // disable stops both outputs
    wr(`ADDR_CTRL, 32'h0000_0000);
    measure(16);
    chk(32'(hi0 + r1), 32'h0000_0000, "outputs while disabled");
    // second reset in mid-run clears every field
    wr(`ADDR_CTRL, 32'h0000_0001);
    rstn_i <= 1'b0;
    repeat (2) @(posedge clk_sys_i);
    chk({30'h0, ch0_o, ch1_o}, 32'h0000_0000, "outputs in reset");
    rstn_i <= 1'b1;
    @(posedge clk_sys_i);
    for (int a = 0; a < 6; a++) begin
      rd(4'(a), got);
      chk(got, 32'h0000_0000, "reset value");
    end
    $display("reset test done");
    // status ignores writes; write then read with no gap
    wr(`ADDR_STATUS, 32'hffff_ffff);
    rd(`ADDR_STATUS, got);
    chk(got, 32'h0000_0000, "status after write");
    addr_i <= `ADDR_CH0_TIMING;
    wdata_i <= 32'hfff1_234c;
    we_i <= 1'b1;
    @(posedge clk_sys_i);
    we_i <= 1'b0;
    re_i <= 1'b1;
    @(posedge clk_sys_i);
    re_i <= 1'b0;
    #1 chk(rdata_o, 32'h0001_234c, "back to back read");
    $display("awkward cases done");
    tally_and_finish();
  end
endmodule
